// File: hw/cdpa_top.sv
// channel dc-block filtering, test source select and phase calibration top
//
// Functional notes
// - high-pass active for any nonzero cutoff code, bypassed at zero
// - per-channel disable removes the high-pass from that channel only
// - coefficient is 2^-(code+1): quarter at code 1, 1/65536 at code 15
// - corner scales with clock and data rate; filter steps once per sample
// - input select can route positive or negative test level instead of input
// - test level is two fifteenths of full scale at any gain
// - one test source shared by all channels
// - phase setting is 10-bit two's complement modulator clock count
// - phase range -osr/2 to osr/2-1, capped at -512 to 511
// - out-of-range phase saturates to nearest limit, never wraps
// - zero phase gives aligned windows of osr modulator samples
// - phase settings move data ready timing with the shifted windows
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
module cdpa_top #(
    parameter int NUM_CH = cdpa_pkg::NCH,
    parameter int DIV = cdpa_pkg::MOD_DIV
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cdpa_pkg::AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_CH-1:0] dec_valid,
    input wire logic [NUM_CH-1:0][cdpa_pkg::DW-1:0] dec_data,
    output logic mod_tick,
    output logic [NUM_CH-1:0] conv_end,
    output logic [NUM_CH-1:0][cdpa_pkg::MUX_W-1:0] input_source_select,
    output logic test_source_on,
    output logic [cdpa_pkg::DW-1:0] test_level_code,
    output logic [NUM_CH-1:0] sample_valid,
    output logic [NUM_CH-1:0][cdpa_pkg::DW-1:0] sample_data,
    output logic data_ready_n
);
    import cdpa_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [CUT_W-1:0] dc_block_cutoff_code;
        logic [OSR_W-1:0] osr_code;
        logic [NUM_CH-1:0][PH_W-1:0] sample_phase_offset;
        logic [NUM_CH-1:0][MUX_W-1:0] mux_cfg;
        logic [NUM_CH-1:0] hp_filter_channel_disable;
        logic [NUM_CH-1:0][DW-1:0] data;
        logic [NUM_CH-1:0] pending;
        logic data_ready_n_n;
        logic [3:0] data_ready_n_cnt;
        logic [31:0] rdata;
        logic [NUM_CH-1:0][MUX_W-1:0] mux_out;
        logic test_on;
        logic [DW-1:0] test_level;
        logic [NUM_CH-1:0] svalid;
        logic [NUM_CH-1:0][DW-1:0] sdata;
    } cdpa_top_s;

    cdpa_top_s st_reg;
    cdpa_top_s st_next;

    logic [NUM_CH-1:0] hpf_valid;
    logic [NUM_CH-1:0][DW-1:0] hpf_data;
    logic tmr_tick;
    logic [NUM_CH-1:0] tmr_end;

    function automatic logic is_test(input logic [MUX_W-1:0] m);
        is_test = (m == MUX_TEST_POS) || (m == MUX_TEST_NEG);
    endfunction : is_test

    // ************************************************************
    // window timing and per-channel filters
    // ************************************************************
    cdpa_phase_timer #(
        .NUM_CH(NUM_CH),
        .DIV(DIV)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .osr_code(st_reg.osr_code),
        .phase_set(st_reg.sample_phase_offset),
        .mod_tick(tmr_tick),
        .conv_end(tmr_end)
    );

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        cdpa_hp_filter u_hpf (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .in_valid(dec_valid[g]),
            .in_data(dec_data[g]),
            .cutoff_code(st_reg.dc_block_cutoff_code),
            .chan_disable(st_reg.hp_filter_channel_disable[g]),
            .out_valid(hpf_valid[g]),
            .out_data(hpf_data[g])
        );
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_next = st_reg;

        // register writes
        if (reg_wr) begin
            if (reg_addr == REG_GLOBAL) begin
                st_next.dc_block_cutoff_code = reg_wdata[CUT_LSB +: CUT_W];
                if (reg_wdata[OSR_LSB +: OSR_W] > OSR_CODE_MAX) begin
                    st_next.osr_code = OSR_CODE_MAX;
                end else begin
                    st_next.osr_code = reg_wdata[OSR_LSB +: OSR_W];
                end
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_addr == ch_addr(REG_CH_CFG_BASE, i)) begin
                    st_next.sample_phase_offset[i] = reg_wdata[PH_LSB +: PH_W];
                    st_next.mux_cfg[i] = reg_wdata[MUX_LSB +: MUX_W];
                    st_next.hp_filter_channel_disable[i] = reg_wdata[DIS_BIT];
                end
            end
        end

        // register reads: data only in the cycle after the strobe
        st_next.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == REG_GLOBAL) begin
                st_next.rdata[CUT_LSB +: CUT_W] = st_reg.dc_block_cutoff_code;
                st_next.rdata[OSR_LSB +: OSR_W] = st_reg.osr_code;
            end
            if (reg_addr == REG_STATUS) begin
                st_next.rdata[ST_PEND_LSB +: NUM_CH] = st_reg.pending;
                st_next.rdata[ST_DATA_READY_N_BIT] = st_reg.data_ready_n_n;
            end
            if (reg_addr == REG_TEST_LEVEL) begin
                st_next.rdata[DW-1:0] = st_reg.test_level;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (reg_addr == ch_addr(REG_CH_CFG_BASE, i)) begin
                    st_next.rdata[PH_LSB +: PH_W] = st_reg.sample_phase_offset[i];
                    st_next.rdata[MUX_LSB +: MUX_W] = st_reg.mux_cfg[i];
                    st_next.rdata[DIS_BIT] = st_reg.hp_filter_channel_disable[i];
                end
                if (reg_addr == ch_addr(REG_CH_DATA_BASE, i)) begin
                    st_next.rdata[DW-1:0] = st_reg.data[i];
                end
            end
        end

        // test source routing
        st_next.test_on = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            st_next.mux_out[i] = st_reg.mux_cfg[i];
            if (is_test(st_reg.mux_cfg[i])) begin
                st_next.test_on = 1'b1;
            end
        end
        // level referred to full scale, so it holds at every gain
        st_next.test_level = TEST_LEVEL;

        // filtered samples and data ready
        st_next.svalid = hpf_valid;
        for (int i = 0; i < NUM_CH; i++) begin
            if (hpf_valid[i]) begin
                st_next.data[i] = hpf_data[i];
                st_next.sdata[i] = hpf_data[i];
            end
        end
        // a sample arriving with the clear counts toward it and is then cleared: clear wins
        st_next.pending = st_reg.pending | hpf_valid;
        if (st_reg.data_ready_n_cnt != '0) begin
            st_next.data_ready_n_cnt = st_reg.data_ready_n_cnt - 4'd1;
            if (st_reg.data_ready_n_cnt == 4'd1) begin
                st_next.data_ready_n_n = 1'b1;
            end
        end
        // latest shifted window decides when data ready falls
        if (&st_next.pending) begin
            st_next.pending = '0;
            st_next.data_ready_n_n = 1'b0;
            st_next.data_ready_n_cnt = DATA_READY_N_LOW_CYC;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.dc_block_cutoff_code <= CUT_RST;
            st_reg.osr_code <= OSR_RST;
            st_reg.data_ready_n_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign mod_tick = tmr_tick;
    assign conv_end = tmr_end;
    assign input_source_select = st_reg.mux_out;
    assign test_source_on = st_reg.test_on;
    assign test_level_code = st_reg.test_level;
    assign sample_valid = st_reg.svalid;
    assign sample_data = st_reg.sdata;
    assign data_ready_n = st_reg.data_ready_n_n;
endmodule : cdpa_top

// File: hw/cdpa_pkg.sv
// shared constants, register map and helpers for the channel dc-block and phase block
package cdpa_pkg;
    localparam int NCH = 4;
    localparam int DW = 24;
    localparam int AW = 8;
    localparam int FRAC = 16;
    localparam int ACCW = DW + FRAC + 2;

    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [AW-1:0] REG_GLOBAL = 8'h00;
    localparam logic [AW-1:0] REG_CH_CFG_BASE = 8'h10;
    localparam logic [AW-1:0] REG_CH_DATA_BASE = 8'h20;
    localparam logic [AW-1:0] REG_STATUS = 8'h30;
    localparam logic [AW-1:0] REG_TEST_LEVEL = 8'h34;

    // global register fields
    localparam int CUT_LSB = 0;
    localparam int CUT_W = 4;
    localparam int OSR_LSB = 4;
    localparam int OSR_W = 4;
    // channel config fields
    localparam int PH_LSB = 0;
    localparam int PH_W = 10;
    localparam int MUX_LSB = 10;
    localparam int MUX_W = 2;
    localparam int DIS_BIT = 12;
    // status fields
    localparam int ST_PEND_LSB = 0;
    localparam int ST_DATA_READY_N_BIT = 8;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [CUT_W-1:0] CUT_BYPASS = 4'h0;
    localparam logic [CUT_W-1:0] CUT_RST = 4'h0;
    localparam logic [OSR_W-1:0] OSR_RST = 4'h4;
    localparam logic [OSR_W-1:0] OSR_CODE_MAX = 4'h8;
    localparam logic [OSR_W-1:0] OSR_CAP_CODE = 4'h4;
    localparam logic [PH_W-1:0] PH_RST = 10'h000;
    localparam logic [MUX_W-1:0] MUX_INPUT = 2'h0;
    localparam logic [MUX_W-1:0] MUX_SHORT = 2'h1;
    localparam logic [MUX_W-1:0] MUX_TEST_POS = 2'h2;
    localparam logic [MUX_W-1:0] MUX_TEST_NEG = 2'h3;
    localparam logic [10:0] PH_HALF_BASE = 11'h020;
    localparam logic signed [10:0] PH_HALF_CAP = 11'sh200;
    localparam logic [14:0] OSR_BASE = 15'h0040;

    // test level: two fifteenths of full scale
    localparam longint TEST_NUM = 2;
    localparam longint TEST_DEN = 15;
    localparam logic [DW-1:0] TEST_LEVEL = DW'((TEST_NUM * (longint'(1) << (DW - 1))) / TEST_DEN);

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int DATA_READY_N_LOW_NS = 500;
    localparam int DATA_READY_N_LOW_CYC_I = (DATA_READY_N_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] DATA_READY_N_LOW_CYC = 4'(DATA_READY_N_LOW_CYC_I < 1 ? 1 : DATA_READY_N_LOW_CYC_I);
    localparam int MOD_DIV = 2;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [14:0] osr_of(input logic [OSR_W-1:0] code);
        osr_of = OSR_BASE << code;
    endfunction : osr_of

    function automatic logic signed [10:0] phase_clip(input logic [PH_W-1:0] ph,
                                                      input logic [OSR_W-1:0] code);
        logic signed [10:0] half;
        logic signed [10:0] v;
        half = (code >= OSR_CAP_CODE) ? PH_HALF_CAP : $signed(11'(PH_HALF_BASE << code));
        v = $signed({ph[PH_W-1], ph});
        if (v > half - 11'sd1) begin
            v = half - 11'sd1;
        end else if (v < -half) begin
            v = -half;
        end
        phase_clip = v;
    endfunction : phase_clip

    function automatic logic [AW-1:0] ch_addr(input logic [AW-1:0] base, input int idx);
        ch_addr = base + AW'(idx * 4);
    endfunction : ch_addr
endpackage : cdpa_pkg

// File: hw/cdpa_hp_filter.sv
// first-order dc-block high-pass filter for one channel
`timescale 1ns/100ps
module cdpa_hp_filter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [cdpa_pkg::DW-1:0] in_data,
    input wire logic [cdpa_pkg::CUT_W-1:0] cutoff_code,
    input wire logic chan_disable,
    output logic out_valid,
    output logic [cdpa_pkg::DW-1:0] out_data
);
    import cdpa_pkg::*;

    typedef struct packed {
        logic [DW-1:0] x_prev;
        logic signed [ACCW-1:0] y;
        logic valid;
        logic [DW-1:0] dout;
    } cdpa_hpf_s;

    cdpa_hpf_s st_reg;
    cdpa_hpf_s st_next;

    localparam logic signed [ACCW-1:0] SAT_HI = ACCW'((longint'(1) << (DW - 1)) - 1);
    localparam logic signed [ACCW-1:0] SAT_LO = -ACCW'(longint'(1) << (DW - 1));

    logic signed [ACCW-1:0] diff_ext;
    logic signed [ACCW-1:0] y_new;
    logic signed [ACCW-1:0] y_int;
    logic [4:0] shift;

    // ************************************************************
    // recursion: y = (x - x_prev) + (1 - a) * y, a = 2^-(code + 1)
    // ************************************************************
    always_comb begin
        st_next = st_reg;
        shift = 5'(cutoff_code) + 5'd1;
        diff_ext = ($signed(ACCW'($signed(in_data))) - $signed(ACCW'($signed(st_reg.x_prev))))
                   <<< FRAC;
        y_new = diff_ext + st_reg.y - (st_reg.y >>> shift);
        y_int = y_new >>> FRAC;
        st_next.valid = in_valid;
        if (in_valid) begin
            st_next.x_prev = in_data;
            if (cutoff_code == CUT_BYPASS || chan_disable) begin
                st_next.y = '0;
                st_next.dout = in_data;
            end else begin
                // one step per output sample, so the corner tracks the data rate
                st_next.y = y_new;
                if (y_int > SAT_HI) begin
                    st_next.dout = SAT_HI[DW-1:0];
                end else if (y_int < SAT_LO) begin
                    st_next.dout = SAT_LO[DW-1:0];
                end else begin
                    st_next.dout = y_int[DW-1:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign out_valid = st_reg.valid;
    assign out_data = st_reg.dout;
endmodule : cdpa_hp_filter

// File: hw/cdpa_phase_timer.sv
// modulator clock enable and per-channel conversion window timing
`timescale 1ns/100ps
module cdpa_phase_timer #(
    parameter int NUM_CH = cdpa_pkg::NCH,
    parameter int DIV = cdpa_pkg::MOD_DIV
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cdpa_pkg::OSR_W-1:0] osr_code,
    input wire logic [NUM_CH-1:0][cdpa_pkg::PH_W-1:0] phase_set,
    output logic mod_tick,
    output logic [NUM_CH-1:0] conv_end
);
    import cdpa_pkg::*;

    typedef struct packed {
        logic [7:0] div_cnt;
        logic tick;
        logic [13:0] mod_cnt;
        logic [NUM_CH-1:0] ends;
    } cdpa_tmr_s;

    cdpa_tmr_s st_reg;
    cdpa_tmr_s st_next;

    logic [15:0] osr;
    logic signed [15:0] end_pt;
    logic signed [10:0] ph;

    always_comb begin
        st_next = st_reg;
        osr = 16'(osr_of(osr_code));
        st_next.ends = '0;
        st_next.tick = 1'b0;
        if (st_reg.div_cnt == 8'(DIV - 1)) begin
            st_next.div_cnt = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 8'd1;
        end
        if (st_reg.tick) begin
            // shared window counter keeps every zero-phase channel aligned
            if (16'(st_reg.mod_cnt) >= osr - 16'd1) begin
                st_next.mod_cnt = '0;
            end else begin
                st_next.mod_cnt = st_reg.mod_cnt + 14'd1;
            end
        end
        end_pt = '0;
        ph = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            ph = phase_clip(phase_set[i], osr_code);
            end_pt = $signed(osr - 16'd1) + 16'(ph);
            if (end_pt >= $signed(osr)) begin
                end_pt = end_pt - $signed(osr);
            end
            if (st_reg.tick && 16'(st_reg.mod_cnt) == 16'(end_pt)) begin
                st_next.ends[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign mod_tick = st_reg.tick;
    assign conv_end = st_reg.ends;
endmodule : cdpa_phase_timer

// File: sim/cdpa_top_assertions.sv
// port checks for the dc-block and phase top
`timescale 1ns/100ps
module cdpa_top_assertions #(
    parameter int NUM_CH = cdpa_pkg::NCH,
    parameter int DIV = cdpa_pkg::MOD_DIV
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [cdpa_pkg::AW-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [NUM_CH-1:0] dec_valid,
    input wire logic mod_tick,
    input wire logic [NUM_CH-1:0] conv_end,
    input wire logic [NUM_CH-1:0][cdpa_pkg::MUX_W-1:0] input_source_select,
    input wire logic test_source_on,
    input wire logic [cdpa_pkg::DW-1:0] test_level_code,
    input wire logic [NUM_CH-1:0] sample_valid,
    input wire logic [NUM_CH-1:0][cdpa_pkg::DW-1:0] sample_data,
    input wire logic data_ready_n
);
    import cdpa_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    logic any_test;
    always_comb begin
        any_test = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            any_test = any_test | input_source_select[i][1];
        end
    end
    // ****
    // properties
    // ****
    property p_tick_div;
        mod_tick |=> !mod_tick ##1 mod_tick;
    endproperty
    a_tick_div: assert property (p_tick_div) else $error("tick spacing wrong");
    property p_conv_tick;
        |conv_end |-> $past(mod_tick);
    endproperty
    a_conv_tick: assert property (p_conv_tick) else $error("window end off tick");
    property p_valid_lat;
        sample_valid == $past(dec_valid, 2);
    endproperty
    a_valid_lat: assert property (p_valid_lat) else $error("sample latency wrong");
    property p_hold;
        !sample_valid[0] |-> $stable(sample_data[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("sample changed without valid");
    property p_data_ready_n_len;
        $fell(data_ready_n) |-> !data_ready_n [*5] ##1 data_ready_n;
    endproperty
    a_data_ready_n_len: assert property (p_data_ready_n_len) else $error("ready pulse length wrong");
    property p_data_ready_n_cause;
        $fell(data_ready_n) |-> |sample_valid;
    endproperty
    a_data_ready_n_cause: assert property (p_data_ready_n_cause) else $error("ready without sample");
    property p_test_lvl;
        $past(rst_n) |-> test_level_code == 24'h111111;
    endproperty
    a_test_lvl: assert property (p_test_lvl) else $error("test level wrong");
    property p_test_on;
        any_test ##1 any_test |-> test_source_on;
    endproperty
    a_test_on: assert property (p_test_on) else $error("test source off");
    property p_test_off;
        !any_test ##1 !any_test |-> !test_source_on;
    endproperty
    a_test_off: assert property (p_test_off) else $error("test source on");
    property p_rd_level;
        reg_rd && reg_addr == REG_TEST_LEVEL |=> reg_rdata[23:0] == 24'h111111;
    endproperty
    a_rd_level: assert property (p_rd_level) else $error("test level read wrong");
    c_data_ready_n: cover property ($fell(data_ready_n));
    c_all: cover property (&sample_valid);
    c_test: cover property (test_source_on);
endmodule : cdpa_top_assertions

// File: sim/cdpa_decim_model.sv
// upstream decimator stand-in: one sample per window end
`timescale 1ns/100ps
module cdpa_decim_model #(
    parameter int NUM_CH = cdpa_pkg::NCH
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [NUM_CH-1:0] conv_end,
    input wire logic [NUM_CH-1:0][cdpa_pkg::DW-1:0] sample_in,
    output logic [NUM_CH-1:0] dec_valid,
    output logic [NUM_CH-1:0][cdpa_pkg::DW-1:0] dec_data
);
    import cdpa_pkg::*;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid <= '0;
            dec_data <= '0;
        end else begin
            dec_valid <= conv_end;
            for (int i = 0; i < NUM_CH; i++) begin
                // no sample on the bus outside a valid pulse
                dec_data[i] <= conv_end[i] ? sample_in[i] : ~dec_data[i];
            end
        end
    end
endmodule : cdpa_decim_model

// File: sim/cdpa_top_test.sv
// testbench for the dc-block and phase top
`timescale 1ns/100ps
module cdpa_top_test;
    import cdpa_pkg::*;
    logic core_clk, rst_n, reg_wr, reg_rd, mod_tick, test_source_on, data_ready_n;
    logic [AW-1:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [NCH-1:0] dec_valid, conv_end, sample_valid;
    logic [NCH-1:0][DW-1:0] dec_data, sample_data, vals;
    logic [NCH-1:0][MUX_W-1:0] input_source_select;
    logic [DW-1:0] test_level_code;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int ce_cyc [NCH];
    logic [9:0] ph_tab [3][3] = '{'{10'h020, 10'h200, 10'h3e0}, '{10'h064, 10'h39c, 10'h005},
                                   '{10'h1ff, 10'h200, 10'h000}};
    int exp_tab [3][3] = '{'{62, 64, 64}, '{126, 128, 10}, '{1022, 3072, 0}};
    int osr_tab [3] = '{0, 1, 5};
    cdpa_top u_cdpa_top (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .dec_valid, .dec_data, .mod_tick, .conv_end, .input_source_select,
        .test_source_on, .test_level_code, .sample_valid, .sample_data, .data_ready_n);
    cdpa_decim_model u_cdpa_decim_model (.core_clk, .rst_n, .conv_end, .sample_in(vals),
        .dec_valid, .dec_data);
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < NCH; i++) begin
            if (conv_end[i]) ce_cyc[i] <= cyc;
        end
        if (cyc == 60000) begin
            failures++;
            test_done();
        end
    end
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic wait_smp();
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        while (sample_valid[0] !== 1'b1 && n < 3000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 3000) chk(32'h0, 32'h1);
    endtask : wait_smp
    function automatic logic [AW-1:0] cfg(input int i);
        cfg = REG_CH_CFG_BASE + AW'(4 * i);
    endfunction : cfg
    task automatic test_done();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    // ****
    // sequence
    // ****
    initial begin
        int p, dd;
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        vals = '0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(REG_GLOBAL, d);
        chk(d, 32'h40);
        rd(REG_TEST_LEVEL, d);
        chk(d, 32'h111111);
        chk(32'(test_level_code), 32'h111111);
        rd(8'h3c, d);
        chk(d, 32'h0);
        wr(REG_GLOBAL, 32'hf0);
        rd(REG_GLOBAL, d);
        chk(d, 32'h80);
        wr(REG_GLOBAL, 32'h0);
        for (int i = 0; i < NCH; i++) vals[i] <= 24'h800123 + DW'(i * 'h10101);
        wait_smp();
        wait_smp();
        chk(32'(sample_valid), 32'hf);
        chk(32'(data_ready_n), 32'h0);
        for (int i = 0; i < NCH; i++) begin
            chk(32'(sample_data[i]), 32'(vals[i]));
            rd(REG_CH_DATA_BASE + AW'(4 * i), d);
            chk({8'h0, d[23:0]}, 32'(vals[i]));
        end
        for (int i = 0; i < NCH; i++) wr(cfg(i), 32'(i) << MUX_LSB);
        repeat (2) @(posedge core_clk);
        #1;
        for (int i = 0; i < NCH; i++) chk(32'(input_source_select[i]), 32'(i));
        chk(32'(test_source_on), 32'h1);
        rd(REG_STATUS, d);
        chk(d, 32'h1 << ST_DATA_READY_N_BIT);
        for (int i = 0; i < NCH; i++) wr(cfg(i), 32'h0);
        repeat (2) @(posedge core_clk);
        #1;
        chk(32'(test_source_on), 32'h0);
        wr(cfg(1), 32'h1 << DIS_BIT);
        rd(cfg(1), d);
        chk(d, 32'h1 << DIS_BIT);
        for (int c = 1; c < 16; c++) begin
            wr(cfg(0), 32'h1 << DIS_BIT);
            vals <= {NCH{24'h001000}};
            wait_smp();
            wr(cfg(0), 32'h0);
            wr(REG_GLOBAL, 32'(c));
            vals <= {NCH{24'h011000}};
            wait_smp();
            chk(32'(sample_data[0]), 32'h10000);
            chk(32'(sample_data[1]), 32'h11000);
            wait_smp();
            chk(32'(sample_data[0]), 32'h10000 - (32'h10000 >> (c + 1)));
        end
        for (int k = 0; k < 3; k++) begin
            wr(REG_GLOBAL, 32'(osr_tab[k]) << OSR_LSB);
            for (int i = 1; i < NCH; i++) wr(cfg(i), 32'(ph_tab[k][i - 1]));
            p = 128 << osr_tab[k];
            repeat (3 * p) @(posedge core_clk);
            #1;
            for (int i = 1; i < NCH; i++) begin
                dd = ce_cyc[i] - ce_cyc[0];
                chk(32'(((dd % p) + p) % p), 32'(exp_tab[k][i - 1]));
            end
        end
        test_done();
    end
endmodule : cdpa_top_test
bind cdpa_top cdpa_top_assertions #(.NUM_CH(NUM_CH), .DIV(DIV)) u_cdpa_top_assertions (
    .core_clk, .rst_n, .reg_addr, .reg_rd, .reg_rdata, .dec_valid, .mod_tick, .conv_end,
    .input_source_select, .test_source_on, .test_level_code, .sample_valid, .sample_data,
    .data_ready_n);
